/* shared/synth_ctrl_pkg.sv */
`default_nettype none
package synth_ctrl_pkg;
  localparam int WORD_W        = 24;
  localparam int CNT_W         = 5;
  // control bit values in the two low bits
  localparam logic [1:0] SEL_REF  = 2'h0;
  localparam logic [1:0] SEL_FB   = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  // function latch field positions
  localparam int POS_CNT_RST   = 2;
  localparam int POS_PD_REQ    = 3;
  localparam int POS_MON_LO    = 4;
  localparam int POS_FL_EN     = 9;
  localparam int POS_FL_MODE   = 10;
  localparam int POS_TO_LO     = 11;
  localparam int POS_CUR1_LO   = 15;
  localparam int POS_CUR2_LO   = 18;
  localparam int POS_PD_SYNC   = 21;
  // feedback latch fast current request position
  localparam int POS_FAST_REQ  = 21;
  localparam logic [23:0] FUNC_RESET = 24'h000000;

  typedef struct packed {
    logic [2:0] current;
    logic       cp_three_state;
    logic       counters_load;
    logic       clk_detect_rst;
    logic       powered_down;
    logic       fastlock_active;
  } pll_ctrl_s;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load;
  } serial_s;
endpackage
`default_nettype wire

/* src/synth_function_latch_ctrl.sv */
// Summary of operation
// - select bits 10 load function latch only
// - counter reset bit holds R and N counters
// - counters leave reset together, aligned
// - power-down bits act only when enabled
// - chip enable low disables two cycles later, after its two-stage sync
// - request with mode 0 powers down immediately
// - request with mode 1 waits pump event
// - power-down loads counters, tristates pump
// - serial register works during power-down
// - three-bit field selects monitor signal
// - enable bit turns fastlock on or off
// - mode bit picks manual or timed exit
// - fast request enters fastlock, current two
// - manual mode exits on written zero
// - timed mode clears request on timeout
// - four-bit code sets timeout length
// - timeout returns to current one
// - timeout counter runs in timed mode only
// - 24 rising clocks, load strobe transfers
// - low current bits first, high second
// - 00 ref, 01 feedback, 11 init latch
`default_nettype none
module synth_function_latch_ctrl
  import synth_ctrl_pkg::*;
#(
  parameter logic [79:0] TIMEOUT_TABLE = {5'h1F, 5'h1E, 5'h1C, 5'h1A,
    5'h18, 5'h16, 5'h14, 5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0A, 5'h08,
    5'h06, 5'h04, 5'h02}
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire synth_ctrl_pkg::serial_s serial_in,
  input  wire logic                   chip_enable_in,
  input  wire logic                   pfd_event_in,
  input  wire logic [7:0]             monitor_sources_in,
  output logic [23:0]                 function_control_latch_out,
  output logic [23:0]                 ref_latch_out,
  output logic [23:0]                 fb_latch_out,
  output logic                        init_pulse_out,
  output synth_ctrl_pkg::pll_ctrl_s   pll_ctrl_out,
  output logic                        monitor_output_pin_out
);
  import synth_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0]        sclk_sync;
    logic [2:0]        load_sync;
    logic [1:0]        data_sync;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] func;
    logic [WORD_W-1:0] ref_l;
    logic [WORD_W-1:0] fb;
    logic              init_p;
    logic              first_fb;
    logic              pd_latched;
    logic              pd_pending;
    logic [CNT_W-1:0]  to_cnt;
    logic              mon;
    logic [1:0]        ce_sync;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic   sclk_rise;
  logic   load_rise;
  logic   pd_any;
  logic   fast_req;
  logic   fl_en;
  logic   fl_timed;
  logic   cnt_rst;
  logic [CNT_W-1:0] to_limit;
  logic [3:0] to_code;

  ////////////////////////////////////////////////////////////////////
  // edges are found only on the second and third stages
  assign sclk_rise = s_q.sclk_sync[1] & ~s_q.sclk_sync[2];
  assign load_rise = s_q.load_sync[1] & ~s_q.load_sync[2];
  assign cnt_rst   = s_q.func[POS_CNT_RST];
  assign fl_en     = s_q.func[POS_FL_EN];
  assign fl_timed  = s_q.func[POS_FL_MODE];
  assign fast_req  = s_q.fb[POS_FAST_REQ];
  assign to_code   = s_q.func[POS_TO_LO +: 4];
  assign to_limit  = TIMEOUT_TABLE[to_code*CNT_W +: CNT_W];
  // chip enable low overrides both programmed bits
  assign pd_any    = ~s_q.ce_sync[1] | s_q.pd_latched;

  always_comb begin
    s_d = s_q;
    s_d.sclk_sync = {s_q.sclk_sync[1:0], serial_in.sclk};
    s_d.load_sync = {s_q.load_sync[1:0], serial_in.load};
    s_d.data_sync = {s_q.data_sync[0], serial_in.sdata};
    s_d.ce_sync   = {s_q.ce_sync[0], chip_enable_in};
    s_d.init_p    = 1'b0;
    // serial path never gated by power-down
    if (sclk_rise) begin
      s_d.shift = {s_q.shift[WORD_W-2:0], s_q.data_sync[1]};
    end
    // fastlock timeout, counts detector events in timed mode
    if (pd_any || !(fl_en && fl_timed && fast_req)) begin
      s_d.to_cnt = '0;
    end else if (pfd_event_in) begin
      if (s_q.to_cnt >= to_limit) begin
        s_d.fb[POS_FAST_REQ] = 1'b0;
        s_d.to_cnt = '0;
      end else begin
        s_d.to_cnt = s_q.to_cnt + CNT_W'(1);
      end
    end
    // synchronous power-down waits on a pump event
    if (s_q.pd_pending && pfd_event_in) begin
      s_d.pd_latched = 1'b1;
      s_d.pd_pending = 1'b0;
    end
    if (load_rise) begin
      case (s_q.shift[1:0])
        SEL_REF: s_d.ref_l = s_q.shift;
        SEL_FB: begin
          s_d.fb = s_q.shift;
          s_d.init_p = s_q.first_fb;
          s_d.first_fb = 1'b0;
        end
        SEL_FUNC, SEL_INIT: begin
          s_d.func = s_q.shift;
          if (s_q.shift[1:0] == SEL_INIT) begin
            s_d.init_p = 1'b1;
            s_d.first_fb = 1'b1;
          end
          if (!s_q.shift[POS_PD_REQ]) begin
            s_d.pd_latched = 1'b0;
            s_d.pd_pending = 1'b0;
          end else if (!s_q.shift[POS_PD_SYNC]) begin
            s_d.pd_latched = 1'b1;
            s_d.pd_pending = 1'b0;
          end else if (!s_q.pd_latched) begin
            s_d.pd_pending = 1'b1;
          end
        end
        default: s_d.func = s_q.func;
      endcase
    end
    s_d.mon = monitor_sources_in[s_q.func[POS_MON_LO +: 3]];
    if (sys_rst_in) begin
      s_d = '0;
      s_d.func = FUNC_RESET;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    pll_ctrl_out = '0;
    pll_ctrl_out.powered_down    = pd_any;
    // held counters release together so both restart aligned
    pll_ctrl_out.counters_load   = pd_any | cnt_rst | s_q.init_p;
    pll_ctrl_out.cp_three_state  = pd_any | cnt_rst | s_q.init_p;
    pll_ctrl_out.clk_detect_rst  = pd_any;
    pll_ctrl_out.fastlock_active = fl_en & fast_req & ~pd_any;
    pll_ctrl_out.current = pll_ctrl_out.fastlock_active ?
      s_q.func[POS_CUR2_LO +: 3] : s_q.func[POS_CUR1_LO +: 3];
  end

  assign function_control_latch_out = s_q.func;
  assign ref_latch_out              = s_q.ref_l;
  assign fb_latch_out               = s_q.fb;
  assign init_pulse_out             = s_q.init_p;
  assign monitor_output_pin_out     = s_q.mon;

  ////////////////////////////////////////////////////////////////////
  // power-down
  a_ce_low_down: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !$past(chip_enable_in, 2) |->
    pll_ctrl_out.powered_down)
    else $error("chip enable low without power-down");
  a_ce_power_up: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) $past(chip_enable_in, 2) && !s_q.pd_latched |->
    !pll_ctrl_out.powered_down)
    else $error("device down without request");
  a_cnt_rst_hold: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) cnt_rst |-> pll_ctrl_out.counters_load)
    else $error("counters not held in reset");
  a_pd_effects: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) pll_ctrl_out.powered_down |->
    pll_ctrl_out.cp_three_state && pll_ctrl_out.clk_detect_rst)
    else $error("power-down effects missing");
  a_pd_load: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) pll_ctrl_out.powered_down |->
    pll_ctrl_out.counters_load)
    else $error("counters not loaded in power-down");
  a_pd_timer_clr: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) pd_any |=> s_q.to_cnt == '0)
    else $error("timer not loaded in power-down");
  a_async_pd: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_FUNC &&
    s_q.shift[POS_PD_REQ] && !s_q.shift[POS_PD_SYNC] |=> s_q.pd_latched)
    else $error("async power-down late");
  a_sync_pd: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) s_q.pd_pending && !pfd_event_in &&
    !load_rise |=> !s_q.pd_latched || $past(s_q.pd_latched))
    else $error("sync power-down before pump event");
  a_sync_entry: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) s_q.pd_pending && pfd_event_in && !load_rise
    |=> s_q.pd_latched)
    else $error("sync power-down missed pump event");
  a_pd_release: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1] &&
    !s_q.shift[POS_PD_REQ] |=> !s_q.pd_latched && !s_q.pd_pending)
    else $error("cleared request left device down");

  // latch capture and reset pulse
  a_shift_in_pd: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) sclk_rise |=>
    s_q.shift[0] == $past(s_q.data_sync[1]))
    else $error("shift register stalled");
  a_shift_hold: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !sclk_rise |=> $stable(s_q.shift))
    else $error("shift without serial clock edge");
  // the timer may clear the request bit in the cycle of a function write
  a_func_only: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_FUNC |=>
    s_q.func == $past(s_q.shift) && $stable(s_q.ref_l) &&
    $stable(s_q.fb[POS_FAST_REQ-1:0]) &&
    $stable(s_q.fb[WORD_W-1:POS_FAST_REQ+1]))
    else $error("function write touched other latch");
  a_ref_capture: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_REF |=>
    s_q.ref_l == $past(s_q.shift) && s_q.func == $past(s_q.func))
    else $error("reference word not captured");
  a_fb_capture: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_FB |=>
    s_q.fb == $past(s_q.shift) && s_q.func == $past(s_q.func))
    else $error("feedback word not captured");
  a_init_capture: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_INIT |=>
    s_q.init_p && s_q.func == $past(s_q.shift))
    else $error("init word without reset pulse");
  a_init_first_fb: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_FB |=>
    s_q.init_p == $past(s_q.first_fb))
    else $error("wrong pulse on feedback load");
  a_init_width: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) s_q.init_p && !load_rise |=> !s_q.init_p)
    else $error("reset pulse longer than one cycle");
  a_load_release: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !cnt_rst && !pd_any && !s_q.init_p |->
    !pll_ctrl_out.counters_load && !pll_ctrl_out.cp_three_state)
    else $error("counters held without cause");

  // fastlock and timer
  a_cur_select: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !pll_ctrl_out.fastlock_active |->
    pll_ctrl_out.current == s_q.func[POS_CUR1_LO +: 3])
    else $error("wrong normal current");
  a_cur_fast: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) pll_ctrl_out.fastlock_active |->
    pll_ctrl_out.current == s_q.func[POS_CUR2_LO +: 3])
    else $error("wrong fastlock current");
  a_fast_off: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !fl_en |-> !pll_ctrl_out.fastlock_active)
    else $error("fastlock active while disabled");
  a_fast_enter: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_FB &&
    s_q.shift[POS_FAST_REQ] && fl_en |=>
    pll_ctrl_out.fastlock_active || pll_ctrl_out.powered_down)
    else $error("fast request did not enter fastlock");
  a_manual_exit: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) load_rise && s_q.shift[1:0] == SEL_FB &&
    !s_q.shift[POS_FAST_REQ] |=> !pll_ctrl_out.fastlock_active)
    else $error("written zero did not end fastlock");
  a_manual_hold: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) fast_req && !fl_timed && !load_rise |=>
    fast_req)
    else $error("manual fastlock exited by itself");
  a_timer_gate: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !fl_timed |=> s_q.to_cnt == '0)
    else $error("timer runs outside timed mode");
  a_mode_timer: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) fl_en && fl_timed && fast_req && !pd_any &&
    pfd_event_in && s_q.to_cnt < to_limit |=>
    s_q.to_cnt == $past(s_q.to_cnt) + CNT_W'(1))
    else $error("timer did not count detector event");
  a_timer_step: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) fl_en && fl_timed && fast_req && !pd_any &&
    !pfd_event_in |=> $stable(s_q.to_cnt))
    else $error("timer moved without detector event");
  a_timer_early: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) fast_req && s_q.to_cnt < to_limit &&
    !load_rise |=> fast_req)
    else $error("timed fastlock ended early");
  a_timed_exit: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) fl_en && fl_timed && fast_req && !pd_any &&
    pfd_event_in && s_q.to_cnt >= to_limit && !load_rise |=>
    !fast_req && pll_ctrl_out.current == s_q.func[POS_CUR1_LO +: 3])
    else $error("timed fastlock did not end");

  // monitor
  a_mon_route: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !$past(sys_rst_in) |->
    monitor_output_pin_out ==
    $past(monitor_sources_in[s_q.func[POS_MON_LO +: 3]]))
    else $error("monitor pin shows wrong source");
endmodule
`default_nettype wire

/* sim/host_model.sv */
`default_nettype none
module host_model (
  input  wire logic                   clk_in,
  output var synth_ctrl_pkg::serial_s serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import synth_ctrl_pkg::*;
  initial serial_out = '0;
  ////////////////////////////////////////////////////////////////////////////
  // serial clock stands still low between frames
  task automatic send(input logic [23:0] word);
    @(negedge clk_in);
    for (int i = 23; i >= 0; i--) begin
      serial_out.sdata = word[i];
      serial_out.sclk  = 1'b0;
      repeat (4) @(negedge clk_in);
      serial_out.sclk  = 1'b1;
      repeat (4) @(negedge clk_in);
    end
    serial_out.sclk  = 1'b0;
    // released data line shows no stale bit
    serial_out.sdata = ~word[0];
    repeat (4) @(negedge clk_in);
    serial_out.load  = 1'b1;
    repeat (4) @(negedge clk_in);
    serial_out.load  = 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import synth_ctrl_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        chip_enable_in = 1'b0;
  logic        pfd_event_in = 1'b0;
  logic [7:0]  monitor_sources_in = 8'h96;
  serial_s     serial;
  logic [23:0] func_lat;
  logic [23:0] ref_lat;
  logic [23:0] fb_lat;
  pll_ctrl_s   ctrl;
  logic        mon_pin;
  logic        init_p;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          init_seen = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  host_model host (.clk_in(sys_clk_in), .serial_out(serial));
  synth_function_latch_ctrl dut (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .serial_in(serial),
    .chip_enable_in(chip_enable_in), .pfd_event_in(pfd_event_in),
    .monitor_sources_in(monitor_sources_in),
    .function_control_latch_out(func_lat), .ref_latch_out(ref_lat),
    .fb_latch_out(fb_lat), .init_pulse_out(init_p), .pll_ctrl_out(ctrl),
    .monitor_output_pin_out(mon_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard: whole run is under 8000 cycles
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  // reset pulse stands one cycle only, so it is counted as it passes
  always @(negedge sys_clk_in) begin
    if (init_p)
      init_seen <= init_seen + 1;
  end
  task automatic chk(input string what, input logic [23:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // latch changes 3 cycles after load rises, 8 leaves margin
  task automatic wr(input logic [23:0] w);
    host.send(w);
    repeat (8) @(negedge sys_clk_in);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge sys_clk_in) pfd_event_in = 1'b1;
      @(negedge sys_clk_in) pfd_event_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    chk("pd", 24'(ctrl.powered_down), 24'h1);
    chip_enable_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    chk("pd", 24'(ctrl.powered_down), 24'h0);
    wr(24'h00ABC0);
    chk("ref", ref_lat, 24'h00ABC0);
    chk("func", func_lat, 24'h000000);
    wr(24'h0012C5);
    chk("fb", fb_lat, 24'h0012C5);
    wr(24'h0A8202);
    chk("func", func_lat, 24'h0A8202);
    chk("ref", ref_lat, 24'h00ABC0);
    chk("cur", 24'(ctrl.current), 24'h5);
    $display("test latch_select done");
    wr(24'h2012C5);
    chk("fast", 24'(ctrl.fastlock_active), 24'h1);
    chk("cur", 24'(ctrl.current), 24'h2);
    pulse(6);
    chk("fast", 24'(ctrl.fastlock_active), 24'h1);
    wr(24'h0012C5);
    chk("cur", 24'(ctrl.current), 24'h5);
    $display("test fastlock_manual done");
    wr(24'h0A8E02);
    wr(24'h2012C5);
    pulse(3);
    chk("fast", 24'(ctrl.fastlock_active), 24'h1);
    pulse(2);
    chk("fast", 24'(ctrl.fastlock_active), 24'h0);
    chk("fb", fb_lat, 24'h0012C5);
    chk("cur", 24'(ctrl.current), 24'h5);
    $display("test fastlock_timed done");
    for (int c = 0; c < 8; c++) begin
      wr(24'h000002 | 24'(c << 4));
      chk("mon", 24'(mon_pin), 24'(monitor_sources_in[c]));
      monitor_sources_in = ~monitor_sources_in;
      repeat (3) @(negedge sys_clk_in);
      chk("mon", 24'(mon_pin), 24'(monitor_sources_in[c]));
    end
    $display("test monitor done");
    wr(24'h000003);
    chk("func", func_lat, 24'h000003);
    chk("init", 24'(init_seen), 24'h1);
    wr(24'h0012C5);
    chk("init", 24'(init_seen), 24'h2);
    wr(24'h0012C5);
    chk("init", 24'(init_seen), 24'h2);
    $display("test init_latch done");
    wr(24'h000006);
    chk("load", 24'(ctrl.counters_load), 24'h1);
    wr(24'h000002);
    chk("load", 24'(ctrl.counters_load), 24'h0);
    wr(24'h00000A);
    chk("pd", 24'(ctrl.powered_down), 24'h1);
    chk("tri", 24'(ctrl.cp_three_state), 24'h1);
    chk("cdr", 24'(ctrl.clk_detect_rst), 24'h1);
    wr(24'h012340);
    chk("ref", ref_lat, 24'h012340);
    wr(24'h000002);
    chk("pd", 24'(ctrl.powered_down), 24'h0);
    wr(24'h20000A);
    chk("pd", 24'(ctrl.powered_down), 24'h0);
    pulse(1);
    chk("pd", 24'(ctrl.powered_down), 24'h1);
    wr(24'h000002);
    chip_enable_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk("pd", 24'(ctrl.powered_down), 24'h1);
    chk("load", 24'(ctrl.counters_load), 24'h1);
    $display("test power_down done");
    end_sim();
  end
endmodule
`default_nettype wire
